/* File: pkg/mpo_pkg.sv */
// ----------------------------------------------------------------------------
// Meter pulse output constants
// ----------------------------------------------------------------------------
package mpo_pkg;

  // --------------------------------------------------------------------------
  // Bus and register map
  // --------------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_CONFIG = 12'h000; // Output configuration code
  localparam logic [11:0] OFF_STATE = 12'h004;  // Controlled on/off state
  localparam logic [11:0] OFF_STATUS = 12'h008; // Block status
  localparam logic [11:0] OFF_RES = 12'h00C;    // Captured resolution code

  // Field positions
  localparam int STATE_FIRST_BIT = 0;
  localparam int STATE_SECOND_BIT = 1;
  localparam int STAT_TYPE_LSB = 0;
  localparam int STAT_CTRL_BIT = 8;
  localparam int STAT_BUSY0_BIT = 9;
  localparam int STAT_BUSY1_BIT = 10;
  localparam int STAT_OUT0_BIT = 11;
  localparam int STAT_OUT1_BIT = 12;
  localparam int STAT_LOCK_BIT = 13;

  // --------------------------------------------------------------------------
  // Output configuration codes
  // --------------------------------------------------------------------------
  localparam logic [6:0] CFG_DEFAULT = 7'h5F; // Count pulses, 32 ms
  localparam logic [6:0] CFG_10MS = 7'h5E;
  localparam logic [6:0] CFG_100MS = 7'h60;
  localparam logic [6:0] CFG_250MS = 7'h5D;
  localparam logic [6:0] CFG_CTRL = 7'h63;    // Data-command control
  localparam logic [1:0] STATE_RESET = 2'h0;

  // Display resolution codes
  localparam logic [8:0] RES_FINE = 9'h077;   // 1 kWh, 0,01 m3
  localparam logic [8:0] RES_MID = 9'h1DF;    // 10 kWh, 0,1 m3
  localparam logic [8:0] RES_COARSE = 9'h1E0; // 100 kWh, 1 m3
  localparam logic [6:0] DIV_FINE = 7'h01;
  localparam logic [6:0] DIV_MID = 7'h0A;
  localparam logic [6:0] DIV_COARSE = 7'h64;

  // Meter types
  localparam logic [3:0] TYPE_HEAT_A = 4'h1;
  localparam logic [3:0] TYPE_HEAT_B = 4'h2;
  localparam logic [3:0] TYPE_HCOOL_A = 4'h3;
  localparam logic [3:0] TYPE_HEAT_C = 4'h4;
  localparam logic [3:0] TYPE_COOL = 4'h5;
  localparam logic [3:0] TYPE_HCOOL_B = 4'h6;
  localparam logic [3:0] TYPE_VOLUME = 4'h7;

  // Counter sources
  typedef enum logic [1:0] {SRC_HEAT, SRC_COOL, SRC_VOL} mpo_src_type;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int PW10_MS = 10;
  localparam int PW32_MS = 32;
  localparam int PW100_MS = 100;
  localparam int PW250_MS = 250;
  localparam int PW10_CYC = PW10_MS * CYC_PER_MS;
  localparam int PW32_CYC = PW32_MS * CYC_PER_MS;
  localparam int PW100_CYC = PW100_MS * CYC_PER_MS;
  localparam int PW250_CYC = PW250_MS * CYC_PER_MS;
  localparam int TIME_W = 22;
  localparam int CNT_W = 16;
  localparam logic [1:0] CAPTURE_AT = 2'h2;

endpackage : mpo_pkg

/* File: design/mpo_pulse_gen.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Burst pulse generator for one output pair
// ----------------------------------------------------------------------------
module mpo_pulse_gen #(
  parameter int CNT_W = 16,
  parameter int TIME_W = 22
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flush,
  input wire logic add_valid,
  input wire logic [CNT_W-1:0] add_count,
  input wire logic [TIME_W-1:0] width_cyc,
  output logic pulse_q,
  output logic busy
);

  typedef enum logic [1:0] {PG_IDLE, PG_HIGH, PG_LOW} mpo_pg_state_type;

  mpo_pg_state_type state_q;
  logic [CNT_W-1:0] pending_q;
  logic [CNT_W-1:0] pending_d;
  logic [TIME_W-1:0] timer_q;
  logic [CNT_W:0] sum;
  logic start;

  assign start = (state_q == PG_IDLE) && (pending_q != '0);
  assign busy = (state_q != PG_IDLE) || (pending_q != '0);

  // Pending pulse count, saturating add of new bursts
  always_comb
  begin
    sum = {1'b0, pending_q} + {1'b0, add_count};
    pending_d = pending_q;
    if (add_valid)
    begin
      pending_d = sum[CNT_W] ? '1 : sum[CNT_W-1:0];
    end
    if (start)
    begin
      pending_d = pending_d - 1'b1;
    end
  end

  // Pending register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pending_q <= '0;
    else if (flush)
      pending_q <= '0;
    else
      pending_q <= pending_d;
  end

  // Fixed rate: high for width, low for width plus one idle cycle before the next pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= PG_IDLE;
      timer_q <= '0;
      pulse_q <= 1'b0;
    end
    else if (flush)
    begin
      state_q <= PG_IDLE;
      timer_q <= '0;
      pulse_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        PG_IDLE:
        begin
          if (start)
          begin
            state_q <= PG_HIGH;
            timer_q <= width_cyc - 1'b1;
            pulse_q <= 1'b1;
          end
        end
        PG_HIGH:
        begin
          if (timer_q == '0)
          begin
            state_q <= PG_LOW;
            timer_q <= width_cyc - 1'b1;
            pulse_q <= 1'b0;
          end
          else
            timer_q <= timer_q - 1'b1;
        end
        PG_LOW:
        begin
          if (timer_q == '0)
            state_q <= PG_IDLE;
          else
            timer_q <= timer_q - 1'b1;
        end
      endcase
    end
  end

  // Flush empties everything
  flush_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    flush |=> !busy && !pulse_q) else $error("flush left generator busy");

endmodule : mpo_pulse_gen

/* File: design/mpo_top.sv */
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Function
// - Outputs form two pairs; both members of a pair carry one signal.
// - Meter type selects which counters feed the first and second pairs.
// - Counter assignment is captured once after reset and never changes.
// - One pulse per increment of the least significant displayed digit.
// - Energy weight 1, 10 or 100 kWh for resolution codes 119, 479, 480.
// - Volume weight 0,01, 0,1 or 1 m3 for the same three codes.
// - Owed pulses gather per interval and leave as a fixed-rate burst.
// - Configuration code 99 hands both pairs to data-command control.
// - In controlled mode commands open (off) or close (on) each pair.
// - Present on/off state of each pair is readable over the bus.
// - Every state change is saved; reset restores the saved state.
// - Configuration code resets to 95: count pulses, 32 ms width.
module mpo_top #(
  parameter int PW10_CYC = mpo_pkg::PW10_CYC,
  parameter int PW32_CYC = mpo_pkg::PW32_CYC,
  parameter int PW100_CYC = mpo_pkg::PW100_CYC,
  parameter int PW250_CYC = mpo_pkg::PW250_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] meter_type,
  input wire logic [8:0] display_resolution_code,
  input wire logic heat_energy_count,
  input wire logic cooling_energy_count,
  input wire logic flow_volume_count,
  input wire logic integ_tick,
  input wire logic [1:0] nvm_saved_state,
  output logic nvm_wr,
  output logic [1:0] nvm_wr_state,
  output logic [1:0] first_output_pair,
  output logic [1:0] second_output_pair
);

  // --------------------------------------------------------------------------
  // Decoding functions
  // --------------------------------------------------------------------------

  // Resolution code to divisor of base increments
  function automatic logic [6:0] res_div(input logic [8:0] code);
    unique case (code)
      mpo_pkg::RES_MID: res_div = mpo_pkg::DIV_MID;
      mpo_pkg::RES_COARSE: res_div = mpo_pkg::DIV_COARSE;
      default: res_div = mpo_pkg::DIV_FINE;
    endcase
  endfunction : res_div

  // Meter type to source of a pair
  function automatic mpo_pkg::mpo_src_type pair_src(input logic [3:0] mt, input logic second);
    unique case (mt)
      mpo_pkg::TYPE_HCOOL_A, mpo_pkg::TYPE_HCOOL_B:
        pair_src = second ? mpo_pkg::SRC_COOL : mpo_pkg::SRC_HEAT;
      mpo_pkg::TYPE_COOL:
        pair_src = second ? mpo_pkg::SRC_VOL : mpo_pkg::SRC_COOL;
      mpo_pkg::TYPE_VOLUME:
        pair_src = mpo_pkg::SRC_VOL;
      default:
        pair_src = second ? mpo_pkg::SRC_VOL : mpo_pkg::SRC_HEAT;
    endcase
  endfunction : pair_src

  // Configuration code to pulse width in cycles
  function automatic logic [21:0] width_of(input logic [6:0] cfg);
    unique case (cfg)
      mpo_pkg::CFG_10MS: width_of = 22'(PW10_CYC);
      mpo_pkg::CFG_100MS: width_of = 22'(PW100_CYC);
      mpo_pkg::CFG_250MS: width_of = 22'(PW250_CYC);
      default: width_of = 22'(PW32_CYC);
    endcase
  endfunction : width_of

  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic [3:0] type_s1_q;
  logic [3:0] type_s2_q;
  logic [8:0] res_s1_q;
  logic [8:0] res_s2_q;
  logic [1:0] nvm_s1_q;
  logic [1:0] nvm_s2_q;
  logic [1:0] cap_cnt_q;
  logic cap_done_q;
  logic [3:0] type_q;
  logic [8:0] res_q;
  logic [6:0] cfg_q;
  logic cfg_written_q;
  logic ctrl_mode_q;
  logic [1:0] state_q;
  logic [1:0] out_q;
  logic [31:0] rdata_q;
  logic setup;
  logic wr_access;
  logic addr_ok;
  logic state_wr;
  logic [2:0] src_inc;
  logic [2:0] src_owed;
  logic [6:0] div;
  mpo_pkg::mpo_src_type sel [2];
  logic [mpo_pkg::CNT_W-1:0] acc_q [2];
  logic [1:0] pulse;
  logic [1:0] busy;
  logic [21:0] width;

  // --------------------------------------------------------------------------
  // Strap and saved-state capture
  // --------------------------------------------------------------------------

  // Two-stage synchronisers for pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      type_s1_q <= '0;
      type_s2_q <= '0;
      res_s1_q <= '0;
      res_s2_q <= '0;
      nvm_s1_q <= '0;
      nvm_s2_q <= '0;
    end
    else
    begin
      type_s1_q <= meter_type;
      type_s2_q <= type_s1_q;
      res_s1_q <= display_resolution_code;
      res_s2_q <= res_s1_q;
      nvm_s1_q <= nvm_saved_state;
      nvm_s2_q <= nvm_s1_q;
    end
  end

  // One-time capture after reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap_cnt_q <= '0;
      cap_done_q <= 1'b0;
      type_q <= '0;
      res_q <= '0;
    end
    else if (!cap_done_q)
    begin
      cap_cnt_q <= cap_cnt_q + 1'b1;
      if (cap_cnt_q == mpo_pkg::CAPTURE_AT)
      begin
        cap_done_q <= 1'b1;
        type_q <= type_s2_q;
        res_q <= res_s2_q;
      end
    end
  end

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign addr_ok = (paddr == mpo_pkg::OFF_CONFIG) || (paddr == mpo_pkg::OFF_STATE)
    || (paddr == mpo_pkg::OFF_STATUS) || (paddr == mpo_pkg::OFF_RES);
  assign state_wr = wr_access && (paddr == mpo_pkg::OFF_STATE) && ctrl_mode_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = rdata_q;

  // Configuration code register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q <= mpo_pkg::CFG_DEFAULT;
      cfg_written_q <= 1'b0;
    end
    else if (wr_access && paddr == mpo_pkg::OFF_CONFIG)
    begin
      cfg_q <= pwdata[6:0];
      cfg_written_q <= 1'b1;
    end
  end

  // Mode follows configuration code
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_mode_q <= 1'b0;
    else
      ctrl_mode_q <= (cfg_q == mpo_pkg::CFG_CTRL);
  end

  // Controlled state: restore, then commands
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= mpo_pkg::STATE_RESET;
    else if (!cap_done_q && cap_cnt_q == mpo_pkg::CAPTURE_AT)
      state_q <= nvm_s2_q;
    else if (state_wr)
      state_q <= pwdata[1:0];
  end

  // Save every change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nvm_wr <= 1'b0;
      nvm_wr_state <= mpo_pkg::STATE_RESET;
    end
    else
    begin
      nvm_wr <= state_wr && (pwdata[1:0] != state_q);
      nvm_wr_state <= state_wr ? pwdata[1:0] : state_q;
    end
  end

  // Read data latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_q <= '0;
    else if (setup)
    begin
      rdata_q <= '0;
      unique case (paddr)
        mpo_pkg::OFF_CONFIG: rdata_q[6:0] <= cfg_q;
        mpo_pkg::OFF_STATE: rdata_q[1:0] <= state_q;
        mpo_pkg::OFF_STATUS:
        begin
          rdata_q[mpo_pkg::STAT_TYPE_LSB +: 4] <= type_q;
          rdata_q[mpo_pkg::STAT_CTRL_BIT] <= ctrl_mode_q;
          rdata_q[mpo_pkg::STAT_BUSY0_BIT] <= busy[0];
          rdata_q[mpo_pkg::STAT_BUSY1_BIT] <= busy[1];
          rdata_q[mpo_pkg::STAT_OUT0_BIT] <= out_q[0];
          rdata_q[mpo_pkg::STAT_OUT1_BIT] <= out_q[1];
          rdata_q[mpo_pkg::STAT_LOCK_BIT] <= cap_done_q;
        end
        mpo_pkg::OFF_RES: rdata_q[8:0] <= res_q;
        default: rdata_q <= '0;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Resolution dividers, one per counter source
  // --------------------------------------------------------------------------
  assign src_inc = {flow_volume_count, cooling_energy_count, heat_energy_count};
  assign div = res_div(res_q);

  generate
    for (genvar s = 0; s < 3; s++)
    begin : g_div
      logic [6:0] pre_q;
      logic wrap;
      assign wrap = src_inc[s] && (pre_q == div - 1'b1);
      assign src_owed[s] = wrap && cap_done_q && !ctrl_mode_q;

      // Count base increments up to one displayed digit
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          pre_q <= '0;
        else if (!cap_done_q || ctrl_mode_q)
          pre_q <= '0;
        else if (src_inc[s])
          pre_q <= wrap ? 7'h00 : pre_q + 1'b1;
      end

      owed_div_a: assert property (@(posedge pclk) disable iff (!presetn)
        pre_q < div)
        else $error("divider passed its digit step");
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Accumulators and burst generators, one per pair
  // --------------------------------------------------------------------------
  assign width = width_of(cfg_q);

  generate
    for (genvar p = 0; p < 2; p++)
    begin : g_pair
      logic owed;
      assign sel[p] = pair_src(type_q, p == 1);
      assign owed = src_owed[sel[p]];

      // Pulses owed in the current interval; new increment wins over clear
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          acc_q[p] <= '0;
        else if (ctrl_mode_q)
          acc_q[p] <= '0;
        else if (integ_tick)
          acc_q[p] <= {{(mpo_pkg::CNT_W-1){1'b0}}, owed};
        else if (owed && acc_q[p] != '1)
          acc_q[p] <= acc_q[p] + 1'b1;
      end

      mpo_pulse_gen #(
        .CNT_W(mpo_pkg::CNT_W),
        .TIME_W(mpo_pkg::TIME_W)
      ) u_gen (
        .pclk(pclk),
        .presetn(presetn),
        .flush(ctrl_mode_q),
        .add_valid(integ_tick && !ctrl_mode_q),
        .add_count(acc_q[p]),
        .width_cyc(width),
        .pulse_q(pulse[p]),
        .busy(busy[p])
      );

      acc_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        integ_tick && !ctrl_mode_q |=> acc_q[p] <= 1) else $error("interval not emptied");
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Output pairs
  // --------------------------------------------------------------------------

  // Command state in controlled mode, bursts otherwise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_q <= '0;
    else if (ctrl_mode_q)
      out_q <= state_q;
    else
      out_q <= pulse;
  end

  // Both members of a pair mirror one register
  assign first_output_pair = {2{out_q[0]}};
  assign second_output_pair = {2{out_q[1]}};

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  pairs_equal_a: assert property (@(posedge pclk) disable iff (!presetn)
    first_output_pair[0] == first_output_pair[1] && second_output_pair[0] == second_output_pair[1])
    else $error("pair members differ");

  pair_source_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_done_q && type_q == mpo_pkg::TYPE_COOL |-> sel[0] == mpo_pkg::SRC_COOL
    && sel[1] == mpo_pkg::SRC_VOL) else $error("cooling meter source wrong");

  type_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_done_q ##1 1'b1 |-> $stable(type_q) && $stable(res_q)) else $error("assignment changed");

  coarse_div_a: assert property (@(posedge pclk) disable iff (!presetn)
    res_q == mpo_pkg::RES_COARSE |-> div == 7'h64) else $error("coarse divisor wrong");

  mode_enter_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_q == mpo_pkg::CFG_CTRL ##1 cfg_q == mpo_pkg::CFG_CTRL |-> ctrl_mode_q)
    else $error("controlled mode not entered");

  cmd_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_mode_q ##1 ctrl_mode_q |-> first_output_pair[0] == $past(state_q[0])
    && second_output_pair[0] == $past(state_q[1])) else $error("command state not driven");

  state_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == mpo_pkg::OFF_STATE |=> prdata[1:0] == $past(state_q))
    else $error("state read mismatch");

  nvm_save_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_wr && pwdata[1:0] != state_q |=> nvm_wr && nvm_wr_state == state_q)
    else $error("state change not saved");

  cfg_default_a: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_written_q |-> cfg_q == mpo_pkg::CFG_DEFAULT) else $error("config default wrong");

  no_burst_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_mode_q ##1 ctrl_mode_q |-> busy == 2'b00) else $error("pulsing in controlled mode");

  ctrl_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(ctrl_mode_q));
  burst_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(first_output_pair[0]) && !ctrl_mode_q);
  save_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
    nvm_wr);

endmodule : mpo_top

/* File: dv/mpo_far_end.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Far-end pulse counter and nonvolatile store
// ----------------------------------------------------------------------------
module mpo_far_end (
  input wire logic pclk,
  input wire logic clr,
  input wire logic [1:0] pair_a,
  input wire logic [1:0] pair_b,
  input wire logic nvm_wr,
  input wire logic [1:0] nvm_wr_state,
  output logic [1:0] nvm_saved_state,
  output int cnt_a,
  output int cnt_b,
  output int hi_len,
  output logic pair_err
);
  logic [1:0] saved_q = 2'h0;
  logic [1:0] last_q = 2'h0;
  int run_q = 0;

  assign nvm_saved_state = saved_q;

  // Store keeps its value across device resets
  always @(posedge pclk)
  begin
    if (nvm_wr === 1'b1)
    begin
      saved_q <= nvm_wr_state;
    end
  end

  // Count rising edges, measure high time, watch pair members
  always @(posedge pclk)
  begin
    last_q <= {pair_b[0], pair_a[0]};
    run_q <= (pair_a[0] === 1'b1) ? run_q + 1 : 0;
    if (pair_a[0] !== 1'b1 && run_q != 0)
    begin
      hi_len <= run_q;
    end
    if (clr)
    begin
      cnt_a <= 0;
      cnt_b <= 0;
      pair_err <= 1'b0;
    end
    else
    begin
      cnt_a <= cnt_a + int'(pair_a[0] === 1'b1 && last_q[0] === 1'b0);
      cnt_b <= cnt_b + int'(pair_b[0] === 1'b1 && last_q[1] === 1'b0);
      pair_err <= pair_err | (pair_a[0] !== pair_a[1]) | (pair_b[0] !== pair_b[1]);
    end
  end
endmodule : mpo_far_end

/* File: dv/mpo_top_tb.sv */
`timescale 1ns/1ps
module mpo_top_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] meter_type = 4'h1;
  logic [8:0] res_code = 9'h077;
  logic [2:0] inc = 3'h0;
  logic tick = 1'b0;
  logic clr = 1'b0;
  logic [1:0] saved;
  logic nvm_wr;
  logic [1:0] nvm_wr_state;
  logic [1:0] pair1;
  logic [1:0] pair2;
  int cnt_a;
  int cnt_b;
  int hi_len;
  logic pair_err;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic er;
  localparam int TYP[4] = '{1, 3, 5, 7};
  localparam logic [8:0] RESV[4] = '{9'h077, 9'h1DF, 9'h1E0, 9'h077};
  localparam logic [6:0] CFGV[4] = '{7'h5F, 7'h5E, 7'h60, 7'h5D};
  localparam int WID[4] = '{8, 4, 12, 16};
  localparam int NH[4] = '{3, 20, 0, 0};
  localparam int NC[4] = '{5, 10, 200, 0};
  localparam int NV[4] = '{2, 7, 100, 2};
  localparam int EXP_A[4] = '{3, 2, 2, 2};
  localparam int EXP_B[4] = '{2, 1, 1, 2};

  mpo_top #(.PW10_CYC(4), .PW32_CYC(8), .PW100_CYC(12), .PW250_CYC(16)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meter_type(meter_type), .display_resolution_code(res_code),
    .heat_energy_count(inc[0]), .cooling_energy_count(inc[1]), .flow_volume_count(inc[2]),
    .integ_tick(tick), .nvm_saved_state(saved), .nvm_wr(nvm_wr),
    .nvm_wr_state(nvm_wr_state), .first_output_pair(pair1), .second_output_pair(pair2));

  mpo_far_end far_u (
    .pclk(pclk), .clr(clr), .pair_a(pair1), .pair_b(pair2), .nvm_wr(nvm_wr),
    .nvm_wr_state(nvm_wr_state), .nvm_saved_state(saved), .cnt_a(cnt_a), .cnt_b(cnt_b),
    .hi_len(hi_len), .pair_err(pair_err));

  // Clock
  initial
  begin
    forever #50 pclk = ~pclk;
  end

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task test_done;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask : chk

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rst(input logic [3:0] t, input logic [8:0] r);
    @(posedge pclk);
    presetn <= 1'b0;
    meter_type <= t;
    res_code <= r;
    clr <= 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    clr <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : rst

  task feed(input int h, input int c, input int v);
    for (int i = 0; i < 200; i++)
    begin
      @(posedge pclk);
      inc <= {i < v, i < c, i < h};
      @(posedge pclk);
      inc <= 3'h0;
    end
    @(posedge pclk);
    tick <= 1'b1;
    @(posedge pclk);
    tick <= 1'b0;
    repeat (4) @(posedge pclk);
    rd = 32'h0000_0600;
    for (int k = 0; k < 200 && rd[10:9] !== 2'h0; k++) apb(1'b0, mpo_pkg::OFF_STATUS, 0);
  endtask : feed

  // Watchdog
  initial
  begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    test_done();
  end

  // ----------------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      rst(TYP[i][3:0], RESV[i]);
      apb(1'b0, mpo_pkg::OFF_CONFIG, 0);
      chk("config", 32'h0000_005F, rd);
      apb(1'b1, mpo_pkg::OFF_CONFIG, {25'h0, CFGV[i]});
      feed(NH[i], NC[i], NV[i]);
      chk("count_a", EXP_A[i], cnt_a);
      chk("count_b", EXP_B[i], cnt_b);
      chk("width", WID[i], hi_len);
    end
    meter_type <= 4'h5;
    apb(1'b0, mpo_pkg::OFF_STATUS, 0);
    chk("type", 32'h7, {28'h0, rd[3:0]});
    apb(1'b1, mpo_pkg::OFF_STATE, 32'h1);
    apb(1'b0, mpo_pkg::OFF_STATE, 0);
    chk("state_ignored", 32'h0, rd);
    apb(1'b1, mpo_pkg::OFF_CONFIG, 32'h63);
    apb(1'b1, mpo_pkg::OFF_STATE, 32'h1);
    apb(1'b0, mpo_pkg::OFF_STATUS, 0);
    chk("ctrl", 32'h1, {31'h0, rd[8]});
    chk("pairs", 32'h3, {28'h0, pair2, pair1});
    apb(1'b0, mpo_pkg::OFF_STATE, 0);
    chk("state", 32'h1, rd);
    feed(0, 0, 50);
    chk("suppress_a", 32'h3, cnt_a);
    chk("suppress", 32'h2, cnt_b);
    chk("hold", 32'h3, {28'h0, pair2, pair1});
    apb(1'b1, mpo_pkg::OFF_STATE, 32'h2);
    rst(4'h7, 9'h077);
    apb(1'b0, mpo_pkg::OFF_STATE, 0);
    chk("restore", 32'h2, rd);
    apb(1'b0, 12'h010, 0);
    chk("unmapped", 32'h1, {31'h0, er});
    chk("pair_err", 32'h0, {31'h0, pair_err});
    test_done();
  end
endmodule : mpo_top_tb
